// File: sim/asd_host.sv
// Serial bus master model for the command decoder link
`timescale 1ns/1ps
module asd_host (
   // Serial link
   output logic      o_sclk,
   output logic      o_cs_n,
   output logic      o_din,
   input  wire logic i_dout
);
   localparam time HALF = 160;
   // Idle bus: clock low, device deselected
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_din  = 1'b0;
   end
   // Select device; odd offset keeps phase unrelated to master clock
   task automatic open_f();
      #(HALF + 13);
      o_cs_n = 1'b0;
      #(HALF * 2);
   endtask
   // Deselect; data line stops showing the last bit
   task automatic close_f();
      #HALF;
      o_cs_n = 1'b1;
      o_din  = ~o_din;
      #(HALF * 2);
   endtask
   // One byte, sampled late in the high phase
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         o_din  = tx[i];
         #HALF;
         o_sclk = 1'b1;
         #HALF;
         rx[i]  = i_dout;
         o_sclk = 1'b0;
      end
   endtask
endmodule

// File: sim/tb.sv
// Self-checking bench for the serial command decoder
`timescale 1ns/1ps
module tb;
   localparam logic [7:0] CODE = 8'h3C; // Arbitrary identification value
   logic        clk = 1'b0;
   logic        resetn, sclk, cs_n, din, dout, oe, strap;
   logic [7:0]  status;
   logic [23:0] data;
   logic        pulse, dev_rst, fixed, ext, clk_oe, chop;
   logic [7:0]  cfg1, fix_sel, diff, sg_lo, sg_hi, mon, io_dir, io_val;
   int          n_mismatch = 0;
   int          cmp_count = 0;
   int          n_pulse = 0;
   int          n_reset = 0;

   asd_decoder #(.DEVICE_CODE(CODE)) asd_decoder_inst (
      .i_clk(clk), .i_resetn(resetn), .i_sclk(sclk), .i_cs_n(cs_n),
      .i_din(din), .o_dout(dout), .o_dout_oe(oe),
      .i_clock_source_pin(strap), .i_status(status), .i_data(data),
      .o_pulse_convert(pulse), .o_device_reset(dev_rst),
      .o_scan_or_fixed_select(fixed), .o_external_path_select(ext),
      .o_clock_output_enable(clk_oe), .o_chop_enable(chop),
      .o_configuration_1(cfg1), .o_fixed_input_select(fix_sel),
      .o_differential_scan_select(diff),
      .o_single_scan_select_low(sg_lo), .o_single_scan_select_high(sg_hi),
      .o_monitor_scan_select(mon), .o_io_direction(io_dir),
      .o_io_value(io_val));
   // Data line as the host sees it: inverse while not driven
   logic        dout_line;
   assign dout_line = oe ? dout : ~dout;
   asd_host asd_host_inst (
      .o_sclk(sclk), .o_cs_n(cs_n), .o_din(din), .i_dout(dout_line));

   // Master clock and pulse counters
   always #20 clk = ~clk;
   always @(posedge clk) begin
      n_pulse += (pulse === 1'b1);
      n_reset += (dev_rst === 1'b1);
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: %s got %h want %h", $time, what,
                  got, exp);
      end
   endtask
   task automatic print_verdict();
      if (n_mismatch == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Link shorthands
   task automatic x(input logic [7:0] tx, output logic [7:0] rx);
      asd_host_inst.xfer(tx, rx);
   endtask
   task automatic rd(input logic [7:0] cmd, input logic [7:0] exp,
                     input string what);
      logic [7:0] r;
      x(cmd, r);
      x(8'h00, r);
      chk(r, exp, what);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [7:0] r;
      x({3'h3, 1'b0, a}, r);
      x(d, r);
   endtask
   task automatic data3();
      logic [7:0] r;
      for (int i = 0; i < 3; i++) begin
         x(8'h00, r);
         chk(r, data[23 - 8 * i -: 8], "data byte");
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic t_defaults();
      chk(cfg1, 8'h83, "cfg1");
      chk(io_dir, 8'hFF, "io dir");
      chk(sg_lo & sg_hi, 8'hFF, "scan sel");
      chk({4'h0, fixed, ext, clk_oe, chop}, 8'h02, "cfg0 out");
   endtask
   task automatic t_burst_read();
      logic [7:0] e [10] = '{8'h0A, 8'h83, 8'h00, 8'h00, 8'hFF, 8'hFF,
                             8'h00, 8'hFF, 8'h00, CODE};
      logic [7:0] r;
      asd_host_inst.open_f();
      x(8'h50, r);
      for (int i = 0; i < 10; i++) begin
         x(8'h00, r);
         chk(r, e[i], "burst read");
      end
      rd(8'h41, 8'h83, "after burst");
      asd_host_inst.close_f();
   endtask
   task automatic t_direct();
      logic [7:0] r;
      asd_host_inst.open_f();
      chk({7'h0, oe}, 8'h01, "oe");
      x(8'hE0, r);
      chk(r, 8'hA5, "status");
      data3();
      wr(4'h1, 8'h00);
      asd_host_inst.close_f();
      asd_host_inst.open_f();
      rd(8'h41, 8'h83, "locked write");
      asd_host_inst.close_f();
   endtask
   task automatic t_burst_write();
      logic [7:0] r;
      logic [7:0] b = 8'h00;
      asd_host_inst.open_f();
      x(8'h72, r);
      for (int i = 0; i < 8; i++) begin
         b = b + 8'h11;
         x(b, r);
      end
      rd(8'h49, CODE, "code");
      rd(8'h48, 8'h77, "io value");
      asd_host_inst.close_f();
      cyc(4);
      chk(diff, 8'h22, "diff");
      chk(mon, 8'h55, "monitor");
      chk(io_val, 8'h77, "io out");
      chk(fix_sel, 8'h00, "fixed gated");
   endtask
   task automatic t_config();
      logic [7:0] r;
      asd_host_inst.open_f();
      wr(4'h0, 8'h7E);
      rd(8'h40, 8'h7E, "cfg0");
      asd_host_inst.close_f();
      cyc(4);
      chk({4'h0, fixed, ext, clk_oe, chop}, 8'h0F, "outs");
      chk(fix_sel, 8'h11, "fixed sel");
      chk(sg_lo | mon, 8'h00, "scan gated");
      strap <= 1'b1;
      cyc(6);
      chk({7'h0, clk_oe}, 8'h00, "strap");
      strap <= 1'b0;
      asd_host_inst.open_f();
      x(8'h00, r);
      chk(r, 8'h12, "fixed direct");
      asd_host_inst.close_f();
      asd_host_inst.open_f();
      x(8'h30, r);
      x(8'h00, r);
      chk(r, 8'hA5, "cmd status");
      data3();
      rd(8'h41, 8'h83, "after cmd");
      wr(4'h0, 8'h08);
      asd_host_inst.close_f();
      asd_host_inst.open_f();
      x(8'h00, r);
      chk(r, 8'h12, "status off");
      asd_host_inst.close_f();
   endtask
   task automatic t_control();
      logic [7:0] r;
      int         p = n_pulse;
      int         q = n_reset;
      asd_host_inst.open_f();
      x(8'h9F, r);
      x(8'hA0, r);
      rd(8'h41, 8'h83, "after reserved");
      wr(4'h3, 8'h5A);
      x(8'hDB, r);
      cyc(8);
      chk(8'(n_pulse - p), 8'h01, "convert pulse");
      chk(8'(n_reset - q), 8'h01, "reset pulse");
      rd(8'h43, 8'h00, "reg3 default");
      rd(8'h40, 8'h0A, "cfg0 default");
      asd_host_inst.close_f();
   endtask
   task automatic t_abort();
      logic [7:0] r;
      asd_host_inst.open_f();
      x(8'h76, r);
      x(8'h07, r);
      asd_host_inst.close_f();
      asd_host_inst.open_f();
      rd(8'h47, 8'hFF, "cs abort");
      asd_host_inst.close_f();
   endtask
   task automatic t_timeout();
      logic [7:0] r;
      asd_host_inst.open_f();
      x(8'h73, r);
      x(8'h01, r);
      cyc(300);
      x(8'h02, r);
      cyc(4200);
      rd(8'h44, 8'h02, "long idle");
      wr(4'h0, 8'h40);
      x(8'h75, r);
      cyc(300);
      rd(8'h45, 8'hFF, "short idle");
      asd_host_inst.close_f();
   endtask

   initial begin
      resetn = 1'b0;
      strap  = 1'b0;
      status = 8'hA5;
      data   = 24'h123456;
      cyc(2);
      resetn <= 1'b1;
      cyc(8);
      t_defaults();
      t_burst_read();
      t_direct();
      t_burst_write();
      t_config();
      t_control();
      t_abort();
      t_timeout();
      print_verdict();
   end
   // Hang guard
   initial begin
      cyc(100000);
      n_mismatch++;
      print_verdict();
   end
endmodule

// File: verilog/asd_decoder.sv
// Serial command decoder and configuration register bank
`timescale 1ns/1ps
`include "asd_regs.svh"
module asd_decoder #(
   parameter logic [7:0] DEVICE_CODE = 8'h5A // Arbitrary value
) (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   // Serial link pins
   input  wire logic        i_sclk,
   input  wire logic        i_cs_n,
   input  wire logic        i_din,
   output logic             o_dout,
   output logic             o_dout_oe,
   // Strap pin
   input  wire logic        i_clock_source_pin,
   // Conversion result from converter
   input  wire logic [7:0]  i_status,
   input  wire logic [23:0] i_data,
   // Converter controls
   output logic             o_pulse_convert,
   output logic             o_device_reset,
   output logic             o_scan_or_fixed_select,
   output logic             o_external_path_select,
   output logic             o_clock_output_enable,
   output logic             o_chop_enable,
   output logic [7:0]       o_configuration_1,
   output logic [7:0]       o_fixed_input_select,
   output logic [7:0]       o_differential_scan_select,
   output logic [7:0]       o_single_scan_select_low,
   output logic [7:0]       o_single_scan_select_high,
   output logic [7:0]       o_monitor_scan_select,
   output logic [7:0]       o_io_direction,
   output logic [7:0]       o_io_value
);
   import asd_pkg::*;

   logic [1:0]       rst_sh;
   logic             rst_n;
   logic [3:0]       pin_raw;
   logic [3:0]       s1;
   logic [3:0]       s2;
   asd_state_t       state, next_state;
   logic [2:0]       bitcnt, next_bitcnt;
   logic [7:0]       rx, next_rx;
   logic [31:0]      tx, next_tx;
   logic [31:0]      pend, next_pend;
   logic             pend_v, next_pend_v;
   logic [3:0]       addr, next_addr;
   logic             burst, next_burst;
   logic [2:0]       bytes, next_bytes;
   logic [2:0]       nbytes, next_nbytes;
   logic [12:0]      idle, next_idle;
   logic             sclk_d, next_sclk_d;
   logic             cs_d, next_cs_d;
   logic [7:0]       regs [0:`ASD_NUM_REGS-1];
   logic [7:0]       next_regs [0:`ASD_NUM_REGS-1];
   logic             next_pulse, next_devrst, next_oe;
   logic [7:0]       rx_byte;
   logic             sclk_rise, sclk_fall, cs_low, cs_rise;
   logic             byte_done, timeout, stat_on;
   logic [12:0]      tmo_lim;
   logic [31:0]      direct_frame;
   logic [2:0]       direct_len;
   logic             mode;

   // Power-on default of each register
   function automatic logic [7:0] reg_default(input int k);
      case (k)
         0: reg_default = `ASD_RST_CFG0;
         1: reg_default = `ASD_RST_CFG1;
         2: reg_default = `ASD_RST_FIXED;
         3: reg_default = `ASD_RST_DIFF;
         4: reg_default = `ASD_RST_SGL_LO;
         5: reg_default = `ASD_RST_SGL_HI;
         6: reg_default = `ASD_RST_MONITOR;
         7: reg_default = `ASD_RST_IO_DIR;
         8: reg_default = `ASD_RST_IO_VAL;
         default: reg_default = 8'h00;
      endcase
   endfunction

   // Read decode; unmapped addresses read zero
   function automatic logic [7:0] reg_read(input logic [3:0] a);
      if (a == `ASD_ADDR_CODE) begin
         reg_read = DEVICE_CODE;
      end else if (a < `ASD_ADDR_CODE) begin
         reg_read = regs[a];
      end else begin
         reg_read = 8'h00;
      end
   endfunction

   // Reset release through two flops
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_sh <= 2'h0;
      end else begin
         rst_sh <= {rst_sh[0], 1'b1};
      end
   end
   assign rst_n = rst_sh[1];

   // Two-flop synchronisers for every pin
   // Reset to each pin's idle level, so no false edge follows reset
   localparam logic [3:0] SYNC_IDLE = 4'h2;
   assign pin_raw = {i_clock_source_pin, i_din, i_cs_n, i_sclk};
   for (genvar g = 0; g < 4; g++) begin : g_sync
      always_ff @(posedge i_clk or negedge rst_n) begin
         if (!rst_n) begin
            s1[g] <= SYNC_IDLE[g];
            s2[g] <= SYNC_IDLE[g];
         end else begin
            s1[g] <= pin_raw[g];
            s2[g] <= s1[g];
         end
      end
   end

   // Edges, byte completion, timeout and direct frame
   assign sclk_rise = s2[0] & ~sclk_d;
   assign sclk_fall = ~s2[0] & sclk_d;
   assign cs_low    = ~s2[1];
   assign cs_rise   = s2[1] & ~cs_d;
   assign rx_byte   = {rx[6:0], s2[2]};
   assign byte_done = cs_low & sclk_rise & (bitcnt == 3'h7);
   assign mode      = regs[0][`ASD_BIT_MODE];
   assign tmo_lim   = regs[0][`ASD_BIT_TMO] ? `ASD_TMO_SHORT
                                              : `ASD_TMO_LONG;
   assign timeout   = cs_low & ~sclk_rise & ~sclk_fall
                      & (idle == tmo_lim - 13'h1);
   assign stat_on   = ~mode & regs[0][`ASD_BIT_STAT];
   assign direct_frame = stat_on ? {i_status, i_data}
                                 : {i_data, 8'h00};
   assign direct_len   = stat_on ? 3'h4 : 3'h3;

   // Next state of the serial interface and register bank
   always_comb begin
      next_state  = state;
      next_bitcnt = bitcnt;
      next_rx     = rx;
      next_tx     = tx;
      next_pend   = pend;
      next_pend_v = pend_v;
      next_addr   = addr;
      next_burst  = burst;
      next_bytes  = bytes;
      next_nbytes = nbytes;
      next_sclk_d = s2[0];
      next_cs_d   = s2[1];
      next_pulse  = 1'b0;
      next_devrst = 1'b0;
      next_oe     = cs_low;
      next_regs   = regs;
      next_idle   = idle;
      // Idle counter of master clock cycles; restarts after a timeout
      if (sclk_rise || sclk_fall || !cs_low || timeout) begin
         next_idle = 13'h0;
      end else if (idle != tmo_lim) begin
         next_idle = idle + 13'h1;
      end
      // Output bits change on the falling serial edge
      if (cs_low && sclk_fall) begin
         if (pend_v) begin
            next_tx     = pend;
            next_pend_v = 1'b0;
         end else begin
            next_tx = {tx[30:0], 1'b0};
         end
      end
      // Input bits taken on the rising serial edge
      if (cs_low && sclk_rise) begin
         next_rx     = rx_byte;
         next_bitcnt = bitcnt + 3'h1;
      end
      if (byte_done) begin
         case (state)
            ST_CMD: begin
               next_addr  = rx_byte[3:0];
               next_burst = rx_byte[4];
               next_bytes = 3'h0;
               case (asd_op_t'(rx_byte[7:5]))
                  OP_DIRECT_LO, OP_DIRECT_HI: begin
                     next_state = ST_DIRECT;
                     next_bytes = 3'h1;
                  end
                  OP_DATA_CMD: begin
                     next_state  = ST_DATA;
                     next_pend   = {i_status, i_data};
                     next_pend_v = 1'b1;
                  end
                  OP_REG_READ: begin
                     next_state  = ST_RD;
                     next_pend   = {reg_read(rx_byte[3:0]), 24'h0};
                     next_pend_v = 1'b1;
                  end
                  OP_REG_WRITE: begin
                     next_state = ST_WR;
                  end
                  OP_PULSE: begin
                     next_pulse = 1'b1;
                  end
                  OP_RESET: begin
                     next_devrst = 1'b1;
                     for (int k = 0; k < `ASD_NUM_REGS; k++) begin
                        next_regs[k] = reg_default(k);
                     end
                  end
                  default: begin
                     next_state = ST_CMD;
                  end
               endcase
            end
            ST_DIRECT: begin
               next_bytes = bytes + 3'h1;
               if (bytes + 3'h1 == nbytes) begin
                  next_state = ST_LOCK;
               end
            end
            ST_DATA: begin
               next_bytes = bytes + 3'h1;
               if (bytes + 3'h1 == `ASD_CMD_BYTES) begin
                  next_state = ST_CMD;
               end
            end
            ST_RD, ST_WR: begin
               if (state == ST_WR && addr < `ASD_ADDR_CODE) begin
                  next_regs[addr] = (addr == `ASD_ADDR_CFG0)
                     ? (rx_byte & `ASD_CFG0_WMASK) : rx_byte;
               end
               if (!burst || addr >= `ASD_ADDR_CODE) begin
                  next_state = ST_CMD;
               end else begin
                  next_addr   = addr + 4'h1;
                  next_pend   = {reg_read(addr + 4'h1), 24'h0};
                  next_pend_v = (state == ST_RD);
               end
            end
            default: begin
               next_state = state;
            end
         endcase
         // Every return to command decode rearms the direct frame
         if (next_state == ST_CMD) begin
            next_pend   = direct_frame;
            next_pend_v = 1'b1;
            next_nbytes = direct_len;
         end
      end
      // Chip select high or idle clock resets the interface
      if (!cs_low || timeout) begin
         next_state  = ST_CMD;
         next_bitcnt = 3'h0;
         next_tx     = direct_frame;
         next_pend_v = 1'b0;
         next_nbytes = direct_len;
      end
   end

   // Register of serial interface and register bank
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         state           <= ST_CMD;
         bitcnt          <= 3'h0;
         rx              <= 8'h00;
         tx              <= 32'h0;
         pend            <= 32'h0;
         pend_v          <= 1'b0;
         addr            <= 4'h0;
         burst           <= 1'b0;
         bytes           <= 3'h0;
         nbytes          <= 3'h4;
         idle            <= 13'h0;
         sclk_d          <= 1'b0;
         cs_d            <= 1'b1;
         o_pulse_convert <= 1'b0;
         o_device_reset  <= 1'b0;
         o_dout_oe       <= 1'b0;
         for (int k = 0; k < `ASD_NUM_REGS; k++) begin
            regs[k] <= reg_default(k);
         end
      end else begin
         state           <= next_state;
         bitcnt          <= next_bitcnt;
         rx              <= next_rx;
         tx              <= next_tx;
         pend            <= next_pend;
         pend_v          <= next_pend_v;
         addr            <= next_addr;
         burst           <= next_burst;
         bytes           <= next_bytes;
         nbytes          <= next_nbytes;
         idle            <= next_idle;
         sclk_d          <= next_sclk_d;
         cs_d            <= next_cs_d;
         o_pulse_convert <= next_pulse;
         o_device_reset  <= next_devrst;
         o_dout_oe       <= next_oe;
         regs            <= next_regs;
      end
   end
   assign o_dout = tx[31];

   // Converter control outputs; input selects gated by mode, clock output enable by strap pin
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_scan_or_fixed_select     <= 1'b0;
         o_external_path_select     <= 1'b0;
         o_clock_output_enable      <= 1'b0;
         o_chop_enable              <= 1'b0;
         o_configuration_1          <= `ASD_RST_CFG1;
         o_fixed_input_select       <= 8'h00;
         o_differential_scan_select <= 8'h00;
         o_single_scan_select_low   <= 8'h00;
         o_single_scan_select_high  <= 8'h00;
         o_monitor_scan_select      <= 8'h00;
         o_io_direction             <= `ASD_RST_IO_DIR;
         o_io_value                 <= `ASD_RST_IO_VAL;
      end else begin
         o_scan_or_fixed_select     <= mode;
         o_external_path_select     <= regs[0][`ASD_BIT_BYPASS];
         o_clock_output_enable      <= regs[0][`ASD_BIT_CLKEN]
                                       & ~s2[3];
         o_chop_enable              <= regs[0][`ASD_BIT_CHOP];
         o_configuration_1          <= regs[1];
         o_fixed_input_select       <= mode ? regs[2] : 8'h00;
         o_differential_scan_select <= mode ? 8'h00 : regs[3];
         o_single_scan_select_low   <= mode ? 8'h00 : regs[4];
         o_single_scan_select_high  <= mode ? 8'h00 : regs[5];
         o_monitor_scan_select      <= mode ? 8'h00 : regs[6];
         o_io_direction             <= regs[7];
         o_io_value                 <= regs[8];
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!rst_n);

   AST_PULSE: assert property (
      byte_done && state == ST_CMD && rx_byte[7:5] == 3'h4
      |=> o_pulse_convert ##1 !o_pulse_convert)
      else $error("pulse convert not issued for one cycle");
   AST_RESET_CMD: assert property (
      byte_done && state == ST_CMD && rx_byte[7:5] == 3'h6
      |=> o_device_reset && regs[0] == `ASD_RST_CFG0
          && regs[4] == `ASD_RST_SGL_LO)
      else $error("reset command did not restore defaults");
   AST_CS_ABORT: assert property (
      cs_rise |=> state == ST_CMD && bitcnt == 3'h0 && !o_dout_oe)
      else $error("chip select high did not reset interface");
   AST_TIMEOUT: assert property (
      timeout |=> state == ST_CMD && bitcnt == 3'h0 && idle == 13'h0)
      else $error("idle timeout did not reset interface");
   AST_BURST_END: assert property (
      byte_done && state == ST_RD && addr == `ASD_ADDR_CODE && cs_low
      && !timeout |=> state == ST_CMD)
      else $error("burst continued past last register");
   AST_INCR: assert property (
      byte_done && state == ST_WR && burst && addr < `ASD_ADDR_CODE
      && !timeout |=> addr == $past(addr) + 4'h1)
      else $error("burst address did not advance");
   AST_LOCK: assert property (
      state == ST_LOCK && cs_low && !timeout |=> state == ST_LOCK)
      else $error("locked interface accepted a command");
   AST_WRITE0: assert property (
      byte_done && state == ST_WR && addr == `ASD_ADDR_CFG0
      && !timeout |=> regs[0] == ($past(rx_byte) & `ASD_CFG0_WMASK))
      else $error("configuration write not stored");
   AST_CLKOUT: assert property (
      ##1 o_clock_output_enable
      |-> $past(regs[0][`ASD_BIT_CLKEN]) && !$past(s2[3]))
      else $error("clock output enabled wrongly");
endmodule

// File: verilog/asd_pkg.sv
// Types of the serial command decoder
package asd_pkg;
   typedef enum logic [2:0] {
      OP_DIRECT_LO = 3'h0,
      OP_DATA_CMD  = 3'h1,
      OP_REG_READ  = 3'h2,
      OP_REG_WRITE = 3'h3,
      OP_PULSE     = 3'h4,
      OP_RESERVED  = 3'h5,
      OP_RESET     = 3'h6,
      OP_DIRECT_HI = 3'h7
   } asd_op_t;
   typedef enum logic [2:0] {
      ST_CMD, ST_DIRECT, ST_DATA, ST_RD, ST_WR, ST_LOCK
   } asd_state_t;
endpackage

// File: verilog/asd_regs.svh
// Register offsets, fields, reset values and counts of the command decoder
`ifndef ASD_REGS_SVH
`define ASD_REGS_SVH
`define ASD_ADDR_CFG0     4'h0
`define ASD_ADDR_CFG1     4'h1
`define ASD_ADDR_FIXED    4'h2
`define ASD_ADDR_DIFF     4'h3
`define ASD_ADDR_SGL_LO   4'h4
`define ASD_ADDR_SGL_HI   4'h5
`define ASD_ADDR_MONITOR  4'h6
`define ASD_ADDR_IO_DIR   4'h7
`define ASD_ADDR_IO_VAL   4'h8
`define ASD_ADDR_CODE     4'h9
`define ASD_RST_CFG0      8'h0A
`define ASD_RST_CFG1      8'h83
`define ASD_RST_FIXED     8'h00
`define ASD_RST_DIFF      8'h00
`define ASD_RST_SGL_LO    8'hFF
`define ASD_RST_SGL_HI    8'hFF
`define ASD_RST_MONITOR   8'h00
`define ASD_RST_IO_DIR    8'hFF
`define ASD_RST_IO_VAL    8'h00
`define ASD_CFG0_WMASK    8'h7E
`define ASD_BIT_TMO       6
`define ASD_BIT_MODE      5
`define ASD_BIT_BYPASS    4
`define ASD_BIT_CLKEN     3
`define ASD_BIT_CHOP      2
`define ASD_BIT_STAT      1
`define ASD_TMO_LONG      13'h1000
`define ASD_TMO_SHORT     13'h0100
`define ASD_CMD_BYTES     3'h4
`define ASD_NUM_REGS      9
`endif
